// [pqp_port_queue_policing.sv]
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

module pqp_port_queue_policing
    import pqp_pkg::*;
#(
    parameter int NUM_PORTS = 7,
    parameter int NUM_QUEUES = 4,
    parameter int COUNT_WIDTH = 24,
    parameter int REFILL_CYCLES = PQP_REFILL_CYCLES
)
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic pktValid,
    input wire logic [2:0] pktPort,
    input wire logic [2:0] pktPriority,
    input wire logic [15:0] pktLength,
    input wire logic pktIsIp,
    input wire logic pktIsSrp,
    input wire logic [1:0] pktDscpColor,
    input wire logic [1:0] pktRemapColor,
    input wire logic [10:0] memLevel,
    output logic resValid,
    output logic [1:0] resQueue,
    output logic [1:0] resColor,
    output logic resDrop,
    output logic resMarkDscp
);

    localparam int NUM_ENTRIES = NUM_PORTS * NUM_QUEUES;
    localparam logic [2:0] LAST_PORT = 3'(NUM_PORTS - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [2:0] portSel;
    logic [1:0] queueSel;
    logic [1:0] queueMap [8];
    logic policeEnable;
    logic colorBlind;
    logic dropSrp;
    logic remapEnable;
    logic markEnable;
    logic [1:0] nonIpColor;
    logic portBased;
    logic [1:0] countType;
    logic dropAll;
    logic droppedColorOnly;
    logic [10:0] memMax;
    logic [10:0] memMin;
    logic [10:0] memScale;

    logic [15:0] committedRate [NUM_ENTRIES];
    logic [15:0] peakRate [NUM_ENTRIES];
    logic [15:0] committedBurst [NUM_ENTRIES];
    logic [15:0] peakBurst [NUM_ENTRIES];
    logic [15:0] committedTokens [NUM_ENTRIES];
    logic [15:0] peakTokens [NUM_ENTRIES];
    logic [COUNT_WIDTH-1:0] eventCount [NUM_ENTRIES][4];

    // Indirect locations follow the pointer; port codes past the last port reach nothing
    wire logic selValid = (portSel <= LAST_PORT);
    wire logic [4:0] selEntry = {portSel, queueSel};

    wire logic wrSelector = regWrite && (regAddr == PQP_OFS_SELECTOR);
    wire logic wrPrioMap = regWrite && (regAddr == PQP_OFS_PRIO_MAP);
    wire logic wrControl = regWrite && (regAddr == PQP_OFS_POLICE_CTRL);
    wire logic wrRates = regWrite && (regAddr == PQP_OFS_RATES) && selValid;
    wire logic wrBursts = regWrite && (regAddr == PQP_OFS_BURSTS) && selValid;
    wire logic wrThresh = regWrite && (regAddr == PQP_OFS_MEM_THRESH);
    wire logic wrScale = regWrite && (regAddr == PQP_OFS_MEM_SCALE);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            portSel <= 3'h0;
            queueSel <= 2'h0;
        end
        else if (wrSelector)
        begin
            portSel <= regWdata[PQP_POS_PORT_SEL +: 3];
            queueSel <= regWdata[PQP_POS_QUEUE_SEL +: 2];
        end
    end

    // Reserved upper bits of each map entry are not stored and read as zero
    always_ff @(posedge core_clk)
    begin
        for (int p = 0; p < 8; p++)
        begin
            if (!resetn)
                queueMap[p] <= PQP_RST_MAP[2*p +: 2];
            else if (wrPrioMap)
                queueMap[p] <= regWdata[4*p +: 2];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            policeEnable <= 1'b0;
            colorBlind <= 1'b0;
            dropSrp <= 1'b0;
            remapEnable <= 1'b0;
            markEnable <= 1'b0;
            nonIpColor <= PQP_RST_NON_IP_COLOR;
            portBased <= 1'b0;
            countType <= 2'h0;
            dropAll <= 1'b0;
            droppedColorOnly <= 1'b0;
        end
        else if (wrControl)
        begin
            policeEnable <= regWdata[PQP_POS_ENABLE];
            colorBlind <= regWdata[PQP_POS_COLOR_BLIND];
            dropSrp <= regWdata[PQP_POS_DROP_SRP];
            remapEnable <= regWdata[PQP_POS_REMAP];
            markEnable <= regWdata[PQP_POS_MARK];
            nonIpColor <= regWdata[PQP_POS_NON_IP_COLOR +: 2];
            portBased <= regWdata[PQP_POS_PORT_BASED];
            countType <= regWdata[PQP_POS_COUNT_TYPE +: 2];
            dropAll <= regWdata[PQP_POS_DROP_ALL];
            droppedColorOnly <= regWdata[PQP_POS_DROPPED_COLOR];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            memMax <= PQP_RST_MEM_MAX;
            memMin <= PQP_RST_MEM_MIN;
            memScale <= PQP_RST_MEM_SCALE;
        end
        else
        begin
            if (wrThresh)
            begin
                memMax <= regWdata[PQP_POS_HIGH_HALF +: 11];
                memMin <= regWdata[10:0];
            end
            if (wrScale)
                memScale <= regWdata[PQP_POS_HIGH_HALF +: 11];
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int e = 0; e < NUM_ENTRIES; e++)
        begin
            if (!resetn)
            begin
                committedRate[e] <= PQP_RST_COMMITTED_RATE;
                peakRate[e] <= PQP_RST_PEAK_RATE;
                committedBurst[e] <= PQP_RST_COMMITTED_BURST;
                peakBurst[e] <= PQP_RST_PEAK_BURST;
            end
            else if (selEntry == 5'(e))
            begin
                if (wrRates)
                begin
                    committedRate[e] <= regWdata[31:16];
                    peakRate[e] <= regWdata[15:0];
                end
                if (wrBursts)
                begin
                    committedBurst[e] <= regWdata[31:16];
                    peakBurst[e] <= regWdata[15:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Classification and metering
    wire logic [1:0] pktQueue = queueMap[pktPriority];
    wire logic [2:0] meterPort = portBased ? pktPort : 3'h0;
    wire logic [4:0] pktEntry = {meterPort, pktQueue};
    // A frame from a port that does not exist is passed unmetered
    wire logic pktMetered = pktValid && policeEnable && (pktPort <= LAST_PORT);

    wire logic [1:0] ipColor = remapEnable ? pktRemapColor : pktDscpColor;
    wire logic [1:0] rawColor = pktIsIp ? ipColor : nonIpColor;
    wire logic [1:0] inColor = colorBlind ? PQP_GREEN : rawColor;

    wire logic committedOk = committedTokens[pktEntry] >= pktLength;
    wire logic peakOk = peakTokens[pktEntry] >= pktLength;
    wire logic inRed = (inColor == PQP_RED);
    wire logic inYellow = (inColor == PQP_YELLOW);

    // Colors only ever get worse than the incoming one in color-aware mode
    wire logic [1:0] meterColor =
        (inRed || !peakOk) ? PQP_RED :
        (inYellow || !committedOk) ? PQP_YELLOW : PQP_GREEN;
    wire logic [1:0] pktColor = pktMetered ? meterColor : PQP_GREEN;

    ////////////////////////////////////////////////////////////////////////////////
    // Packet-memory WRED
    logic [15:0] lfsr;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            lfsr <= PQP_RST_LFSR;
        else
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    wire logic randomHit = lfsr[10:0] < memScale;
    wire logic aboveMax = memLevel > memMax;
    wire logic aboveMin = memLevel > memMin;
    // Between thresholds only red packets are candidates; the trade is a simple
    // comparator instead of a true average-queue probability ramp
    wire logic wredHit =
        aboveMax ? (dropAll || randomHit) :
        (aboveMin && (meterColor == PQP_RED) && randomHit);
    wire logic srpSafe = pktIsSrp && !dropSrp;
    wire logic pktDrop = pktMetered && wredHit && !srpSafe;

    ////////////////////////////////////////////////////////////////////////////////
    // Token buckets
    logic [$clog2(REFILL_CYCLES+1)-1:0] refillCount;
    wire logic refillTick = (refillCount == '0);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            refillCount <= ($clog2(REFILL_CYCLES+1))'(REFILL_CYCLES - 1);
        else if (refillTick)
            refillCount <= ($clog2(REFILL_CYCLES+1))'(REFILL_CYCLES - 1);
        else
            refillCount <= refillCount - 1'b1;
    end

    // Dropped frames take no tokens; a consumed amount never exceeds the bucket
    wire logic takeCommitted = pktMetered && !pktDrop && (meterColor == PQP_GREEN);
    wire logic takePeak = pktMetered && !pktDrop && (meterColor != PQP_RED);

    logic [15:0] next_committedTokens [NUM_ENTRIES];
    logic [15:0] next_peakTokens [NUM_ENTRIES];

    always_comb
    begin
        for (int e = 0; e < NUM_ENTRIES; e++)
        begin
            logic [15:0] cLeft;
            logic [15:0] pLeft;
            logic [16:0] cSum;
            logic [16:0] pSum;
            cLeft = committedTokens[e];
            pLeft = peakTokens[e];
            if (takeCommitted && (pktEntry == 5'(e)))
                cLeft = committedTokens[e] - pktLength;
            if (takePeak && (pktEntry == 5'(e)))
                pLeft = peakTokens[e] - pktLength;
            cSum = {1'b0, cLeft} + (refillTick ? {1'b0, committedRate[e]} : 17'h0);
            pSum = {1'b0, pLeft} + (refillTick ? {1'b0, peakRate[e]} : 17'h0);
            next_committedTokens[e] =
                (cSum > {1'b0, committedBurst[e]}) ? committedBurst[e] : cSum[15:0];
            next_peakTokens[e] =
                (pSum > {1'b0, peakBurst[e]}) ? peakBurst[e] : pSum[15:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        for (int e = 0; e < NUM_ENTRIES; e++)
        begin
            if (!resetn)
            begin
                committedTokens[e] <= PQP_RST_COMMITTED_BURST;
                peakTokens[e] <= PQP_RST_PEAK_BURST;
            end
            else
            begin
                committedTokens[e] <= next_committedTokens[e];
                peakTokens[e] <= next_peakTokens[e];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event counters, saturating so a long run never wraps to a small value
    wire logic countColor = pktMetered && (!droppedColorOnly || pktDrop);

    always_ff @(posedge core_clk)
    begin
        for (int e = 0; e < NUM_ENTRIES; e++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (!resetn)
                    eventCount[e][k] <= '0;
                else if ((pktEntry == 5'(e)) && (&eventCount[e][k] == 1'b0))
                begin
                    if (k == int'(PQP_DROPPED))
                    begin
                        if (pktMetered && pktDrop)
                            eventCount[e][k] <= eventCount[e][k] + 1'b1;
                    end
                    else if (countColor && (meterColor == 2'(k)))
                        eventCount[e][k] <= eventCount[e][k] + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Results
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            resValid <= 1'b0;
            resQueue <= 2'h0;
            resColor <= PQP_GREEN;
            resDrop <= 1'b0;
            resMarkDscp <= 1'b0;
        end
        else
        begin
            resValid <= pktValid;
            resQueue <= pktQueue;
            resColor <= pktColor;
            resDrop <= pktDrop;
            resMarkDscp <= pktMetered && markEnable && !pktDrop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read
    logic [31:0] mapWord;

    always_comb
    begin
        mapWord = 32'h0;
        for (int p = 0; p < 8; p++)
            mapWord[4*p +: 2] = queueMap[p];
    end

    wire logic [31:0] selWord = {13'h0, portSel, 14'h0, queueSel};
    wire logic [31:0] ctrlWord = {20'h0, droppedColorOnly, dropAll, countType, portBased,
        nonIpColor, markEnable, remapEnable, dropSrp, colorBlind, policeEnable};
    wire logic [31:0] rateWord = selValid ?
        {committedRate[selEntry], peakRate[selEntry]} : 32'h0;
    wire logic [31:0] burstWord = selValid ?
        {committedBurst[selEntry], peakBurst[selEntry]} : 32'h0;
    wire logic [31:0] countWord = selValid ?
        32'(eventCount[selEntry][countType]) : 32'h0;
    wire logic [31:0] threshWord = {5'h0, memMax, 5'h0, memMin};
    wire logic [31:0] scaleWord = {5'h0, memScale, 16'h0};

    wire logic [31:0] readWord =
        (regAddr == PQP_OFS_SELECTOR) ? selWord :
        (regAddr == PQP_OFS_PRIO_MAP) ? mapWord :
        (regAddr == PQP_OFS_POLICE_CTRL) ? ctrlWord :
        (regAddr == PQP_OFS_RATES) ? rateWord :
        (regAddr == PQP_OFS_BURSTS) ? burstWord :
        (regAddr == PQP_OFS_MEM_THRESH) ? threshWord :
        (regAddr == PQP_OFS_MEM_SCALE) ? scaleWord :
        (regAddr == PQP_OFS_EVENT_COUNT) ? countWord : 32'h0;

    always_ff @(posedge core_clk)
    begin
        regRdata <= (resetn && regRead) ? readWord : 32'h0;
    end

endmodule : pqp_port_queue_policing

// [pqp_pkg.sv]
package pqp_pkg;
    // Register byte offsets
    localparam logic [11:0] PQP_OFS_SELECTOR = 12'h804;
    localparam logic [11:0] PQP_OFS_PRIO_MAP = 12'h808;
    localparam logic [11:0] PQP_OFS_POLICE_CTRL = 12'h80C;
    localparam logic [11:0] PQP_OFS_RATES = 12'h820;
    localparam logic [11:0] PQP_OFS_BURSTS = 12'h824;
    localparam logic [11:0] PQP_OFS_MEM_THRESH = 12'h830;
    localparam logic [11:0] PQP_OFS_MEM_SCALE = 12'h834;
    localparam logic [11:0] PQP_OFS_EVENT_COUNT = 12'h850;

    // Field positions
    localparam int PQP_POS_PORT_SEL = 16;
    localparam int PQP_POS_QUEUE_SEL = 0;
    localparam int PQP_POS_ENABLE = 0;
    localparam int PQP_POS_COLOR_BLIND = 1;
    localparam int PQP_POS_DROP_SRP = 2;
    localparam int PQP_POS_REMAP = 3;
    localparam int PQP_POS_MARK = 4;
    localparam int PQP_POS_NON_IP_COLOR = 5;
    localparam int PQP_POS_PORT_BASED = 7;
    localparam int PQP_POS_COUNT_TYPE = 8;
    localparam int PQP_POS_DROP_ALL = 10;
    localparam int PQP_POS_DROPPED_COLOR = 11;
    localparam int PQP_POS_HIGH_HALF = 16;

    // Reset values
    localparam logic [15:0] PQP_RST_MAP = 16'hFA50;
    localparam logic [1:0] PQP_RST_NON_IP_COLOR = 2'h1;
    localparam logic [15:0] PQP_RST_COMMITTED_RATE = 16'h1000;
    localparam logic [15:0] PQP_RST_PEAK_RATE = 16'h2000;
    localparam logic [15:0] PQP_RST_COMMITTED_BURST = 16'h1000;
    localparam logic [15:0] PQP_RST_PEAK_BURST = 16'h3000;
    localparam logic [10:0] PQP_RST_MEM_MAX = 11'h400;
    localparam logic [10:0] PQP_RST_MEM_MIN = 11'h080;
    localparam logic [10:0] PQP_RST_MEM_SCALE = 11'h020;
    localparam logic [15:0] PQP_RST_LFSR = 16'hACE1;

    // Token refill interval
    localparam int PQP_REFILL_NS = 50000;
    localparam int PQP_CLK_MHZ = 20;
    localparam int PQP_REFILL_CYCLES = (PQP_REFILL_NS * PQP_CLK_MHZ) / 1000;

    // Meter colors; the same codes select the event counter
    typedef enum logic [1:0]
    {
        PQP_DROPPED = 2'b00,
        PQP_GREEN = 2'b01,
        PQP_YELLOW = 2'b10,
        PQP_RED = 2'b11
    } pqp_color_e;
endpackage : pqp_pkg

// [pqp_port_queue_policing_checker.sv]
`timescale 1ns/1ps
module pqp_policing_checker
    import pqp_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [11:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic pktValid,
    input wire logic [2:0] pktPort,
    input wire logic [2:0] pktPriority,
    input wire logic pktIsSrp,
    input wire logic [10:0] memLevel,
    input wire logic resValid,
    input wire logic [1:0] resQueue,
    input wire logic [1:0] resColor,
    input wire logic resDrop,
    input wire logic resMarkDscp
);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of the map, control and upper-threshold fields, so results can be tied to what software set
    logic [31:0] mapS;
    logic [11:0] ctrlS;
    logic [10:0] maxS;
    wire wrMap = regWrite && regAddr == PQP_OFS_PRIO_MAP;
    wire wrCtrl = regWrite && regAddr == PQP_OFS_POLICE_CTRL;
    wire wrThr = regWrite && regAddr == PQP_OFS_MEM_THRESH;
    wire [1:0] qExp = mapS[{pktPriority, 2'b00} +: 2];
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            mapS <= 32'h33221100;
            ctrlS <= 12'h020;
            maxS <= 11'h400;
        end
        else
        begin
            mapS <= wrMap ? (regWdata & 32'h33333333) : mapS;
            ctrlS <= wrCtrl ? regWdata[11:0] : ctrlS;
            maxS <= wrThr ? regWdata[26:16] : maxS;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_read_window: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data outside its cycle");
    chk_result_delay: assert property (resValid == $past(pktValid))
        else $error("result valid not one cycle after packet");
    chk_queue_map: assert property (pktValid |=> resQueue == $past(qExp))
        else $error("queue differs from priority map");
    chk_sel_reserved: assert property (regRead && regAddr == PQP_OFS_SELECTOR
        |=> (regRdata & 32'hFFF8FFFC) == 32'h0) else $error("selector reserved bits set");
    chk_map_echo: assert property (regRead && regAddr == PQP_OFS_PRIO_MAP |=> regRdata == mapS)
        else $error("map readback wrong");
    chk_ctrl_echo: assert property (regRead && regAddr == PQP_OFS_POLICE_CTRL
        |=> regRdata == {20'h0, ctrlS}) else $error("control readback wrong");
    chk_off_green: assert property (pktValid && !ctrlS[0]
        |=> resColor == PQP_GREEN && !resDrop && !resMarkDscp) else $error("unpoliced packet touched");
    chk_srp_kept: assert property (pktValid && pktIsSrp && !ctrlS[2] |=> !resDrop)
        else $error("reserved stream packet dropped");
    chk_drop_all: assert property (pktValid && ctrlS[0] && ctrlS[10] && !pktIsSrp
        && pktPort != 3'h7 && memLevel > maxS |=> resDrop) else $error("drop all missed");
    chk_mark_kept: assert property (resMarkDscp |-> resValid && !resDrop && $past(ctrlS[4]))
        else $error("mark without cause");
endmodule : pqp_policing_checker

bind pqp_port_queue_policing pqp_policing_checker u_chk (.core_clk(core_clk), .resetn(resetn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pktValid(pktValid), .pktPort(pktPort), .pktPriority(pktPriority),
    .pktIsSrp(pktIsSrp), .memLevel(memLevel), .resValid(resValid), .resQueue(resQueue),
    .resColor(resColor), .resDrop(resDrop), .resMarkDscp(resMarkDscp));

// [pqp_port_queue_policing_test.sv]
`timescale 1ns/1ps
module pqp_port_queue_policing_test
    import pqp_pkg::*;
;
    logic core_clk, resetn, regWrite, regRead, pktValid, pktIsIp, pktIsSrp;
    logic resValid, resDrop, resMarkDscp;
    logic [11:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [2:0] pktPort, pktPriority;
    logic [15:0] pktLength;
    logic [1:0] pktDscpColor, pktRemapColor, resQueue, resColor;
    logic [10:0] memLevel;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;

    // Short refill interval keeps the run brief; rates are zeroed where tokens are counted
    pqp_port_queue_policing #(.REFILL_CYCLES(8)) u_dut (.core_clk(core_clk), .resetn(resetn),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .pktValid(pktValid), .pktPort(pktPort), .pktPriority(pktPriority),
        .pktLength(pktLength), .pktIsIp(pktIsIp), .pktIsSrp(pktIsSrp),
        .pktDscpColor(pktDscpColor), .pktRemapColor(pktRemapColor), .memLevel(memLevel),
        .resValid(resValid), .resQueue(resQueue), .resColor(resColor), .resDrop(resDrop),
        .resMarkDscp(resMarkDscp));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        check(n, e, regRdata);
    endtask : rdc

    // f packs {ip, srp, dscp color, remap color}; e packs {drop, mark, color, queue}
    task automatic pkc(input string n, input logic [2:0] p, input logic [2:0] pr,
        input logic [15:0] l, input logic [5:0] f, input logic [10:0] m, input logic [5:0] e);
        @(posedge core_clk);
        pktValid <= 1'b1;
        pktPort <= p;
        pktPriority <= pr;
        pktLength <= l;
        {pktIsIp, pktIsSrp, pktDscpColor, pktRemapColor} <= f;
        memLevel <= m;
        @(posedge core_clk);
        pktValid <= 1'b0;
        #1;
        check(n, {25'h0, 1'b1, e}, {25'h0, resValid, resDrop, resMarkDscp, resColor, resQueue});
    endtask : pkc

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc("selector", PQP_OFS_SELECTOR, 32'h0);
        rdc("map", PQP_OFS_PRIO_MAP, 32'h33221100);
        rdc("control", PQP_OFS_POLICE_CTRL, 32'h00000020);
        rdc("rates", PQP_OFS_RATES, 32'h10002000);
        rdc("bursts", PQP_OFS_BURSTS, 32'h10003000);
        rdc("thresholds", PQP_OFS_MEM_THRESH, 32'h04000080);
        rdc("scale", PQP_OFS_MEM_SCALE, 32'h00200000);
        rdc("unmapped", 12'h900, 32'h0);
    endtask : t_reset

    task automatic t_indirect;
        wr(PQP_OFS_SELECTOR, 32'hFFFFFFFF);
        rdc("selector mask", PQP_OFS_SELECTOR, 32'h00070003);
        wr(PQP_OFS_RATES, 32'hDEADBEEF);
        rdc("rates no port", PQP_OFS_RATES, 32'h0);
        wr(PQP_OFS_SELECTOR, 32'h00030002);
        wr(PQP_OFS_RATES, 32'hAAAA5555);
        wr(PQP_OFS_BURSTS, 32'h12345678);
        rdc("rates p3q2", PQP_OFS_RATES, 32'hAAAA5555);
        rdc("bursts p3q2", PQP_OFS_BURSTS, 32'h12345678);
        wr(PQP_OFS_SELECTOR, 32'h00030001);
        rdc("rates p3q1", PQP_OFS_RATES, 32'h10002000);
        wr(PQP_OFS_SELECTOR, 32'h00020002);
        rdc("bursts p2q2", PQP_OFS_BURSTS, 32'h10003000);
        wr(PQP_OFS_SELECTOR, 32'h00030002);
        rdc("rates back", PQP_OFS_RATES, 32'hAAAA5555);
    endtask : t_indirect

    task automatic t_map;
        int i;
        wr(PQP_OFS_PRIO_MAP, 32'hFFFFFFFF);
        rdc("map mask", PQP_OFS_PRIO_MAP, 32'h33333333);
        wr(PQP_OFS_PRIO_MAP, 32'h01234567);
        rdc("map", PQP_OFS_PRIO_MAP, 32'h01230123);
        for (i = 0; i < 8; i++)
            pkc("queue", 3'h1, i[2:0], 16'd64, 6'h0, 11'h7FF, {2'b00, PQP_GREEN, 2'd3 - i[1:0]});
        wr(PQP_OFS_PRIO_MAP, 32'h33221100);
    endtask : t_map

    task automatic t_color;
        wr(PQP_OFS_POLICE_CTRL, 32'hFFFFFFFF);
        rdc("control mask", PQP_OFS_POLICE_CTRL, 32'h00000FFF);
        wr(PQP_OFS_POLICE_CTRL, 32'h00000051);
        pkc("aware dscp", 3'h0, 3'h0, 16'd64, 6'b101011, 11'h0, {2'b01, PQP_YELLOW, 2'd0});
        pkc("non ip", 3'h0, 3'h0, 16'd64, 6'b001100, 11'h0, {2'b01, PQP_YELLOW, 2'd0});
        wr(PQP_OFS_POLICE_CTRL, 32'h00000059);
        pkc("remap", 3'h0, 3'h0, 16'd64, 6'b101011, 11'h0, {2'b01, PQP_RED, 2'd0});
        wr(PQP_OFS_POLICE_CTRL, 32'h0000004B);
        pkc("blind", 3'h0, 3'h0, 16'd64, 6'b101111, 11'h0, {2'b00, PQP_GREEN, 2'd0});
    endtask : t_color

    task automatic t_meter;
        int i;
        logic [31:0] cnt [4] = '{32'd0, 32'd2, 32'd4, 32'd1};
        wr(PQP_OFS_SELECTOR, 32'h00000003);
        wr(PQP_OFS_RATES, 32'h0);
        wr(PQP_OFS_POLICE_CTRL, 32'h00000003);
        // Port 5 lands on port 0 entries while per-port policing is off
        for (i = 0; i < 7; i++)
            pkc("tokens", 3'h5, 3'h7, 16'h0800, 6'h0, 11'h0,
                {2'b00, i < 2 ? PQP_GREEN : (i < 6 ? PQP_YELLOW : PQP_RED), 2'd3});
        for (i = 0; i < 4; i++)
        begin
            wr(PQP_OFS_POLICE_CTRL, 32'h00000003 | (i << 8));
            rdc("counter", PQP_OFS_EVENT_COUNT, cnt[i]);
        end
        wr(PQP_OFS_POLICE_CTRL, 32'h00000083);
        pkc("per port", 3'h5, 3'h7, 16'h0800, 6'h0, 11'h0, {2'b00, PQP_GREEN, 2'd3});
    endtask : t_meter

    task automatic t_drop;
        wr(PQP_OFS_MEM_THRESH, 32'hFFFFFFFF);
        rdc("threshold mask", PQP_OFS_MEM_THRESH, 32'h07FF07FF);
        wr(PQP_OFS_MEM_THRESH, 32'h04000080);
        wr(PQP_OFS_SELECTOR, 32'h0);
        wr(PQP_OFS_MEM_SCALE, 32'h0);
        wr(PQP_OFS_POLICE_CTRL, 32'h00000403);
        pkc("over max", 3'h0, 3'h0, 16'd64, 6'h0, 11'h401, {2'b10, PQP_GREEN, 2'd0});
        pkc("srp kept", 3'h0, 3'h0, 16'd64, 6'h10, 11'h401, {2'b00, PQP_GREEN, 2'd0});
        pkc("at max", 3'h0, 3'h0, 16'd64, 6'h0, 11'h400, {2'b00, PQP_GREEN, 2'd0});
        wr(PQP_OFS_POLICE_CTRL, 32'h00000407);
        pkc("srp drop", 3'h0, 3'h0, 16'd64, 6'h10, 11'h401, {2'b10, PQP_GREEN, 2'd0});
        wr(PQP_OFS_POLICE_CTRL, 32'h00000003);
        pkc("scaled", 3'h0, 3'h0, 16'd64, 6'h0, 11'h401, {2'b00, PQP_GREEN, 2'd0});
        rdc("drop count", PQP_OFS_EVENT_COUNT, 32'd2);
        // Six green packets of entry 0 were counted before; now only dropped greens add
        wr(PQP_OFS_POLICE_CTRL, 32'h00000C03);
        pkc("dropped only", 3'h0, 3'h0, 16'd64, 6'h0, 11'h401, {2'b10, PQP_GREEN, 2'd0});
        pkc("kept uncounted", 3'h0, 3'h0, 16'd64, 6'h0, 11'h0, {2'b00, PQP_GREEN, 2'd0});
        wr(PQP_OFS_POLICE_CTRL, 32'h00000903);
        rdc("green dropped", PQP_OFS_EVENT_COUNT, 32'd7);
    endtask : t_drop

    task automatic results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // A hang is cut off well beyond the fewer than 200 cycles the sequence needs
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            results();
        end
    end

    initial
    begin
        {resetn, regWrite, regRead, pktValid, pktIsIp, pktIsSrp} = 6'h0;
        {regAddr, regWdata, pktPort, pktPriority, pktLength} = '0;
        {pktDscpColor, pktRemapColor, memLevel} = '0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_indirect();
        t_map();
        t_color();
        t_meter();
        t_drop();
        results();
    end
endmodule : pqp_port_queue_policing_test
